// File: design/fsr_cfg.svh
// Constants for the flash suspend, reset and protection command block
// What this block does
// - Gang lock and unlock act only after write-protect-select has executed.
// - Gang lock protects every dynamic bit; gang unlock clears every dynamic bit.
// - Host sends write enable, then a lone 7Eh or 98h opcode byte.
// - Gang opcodes are rejected unless chip select rises on a byte boundary.
// - Sector is unprotected only when dynamic and solid bits are both zero.
// - While suspended, reads are allowed except the suspended page or sector.
// - Security status bit 2 flags program suspend, bit 3 flags erase suspend.
// - A suspend waits its program or erase suspend latency before suspended.
// - Entering suspend clears write-enable latch and sets the matching flag.
// - Latency-group commands during suspend are accepted only after the latency.
// - Any-time group commands are accepted throughout suspend without waiting.
// - Resume sets write-enable latch and write-in-progress, clears suspend flag.
// - Completion of a resumed operation clears latch and write-in-progress.
// - Resume is ignored while continuous-read enhancement mode is active.
// - No-operation only cancels a pending reset arm; one byte in either mode.
// - Reset runs only right after reset arm; anything else cancels the arm.
// - Software reset returns to standby with all volatile state at defaults.
// - Software reset aborts a running program or erase operation.
// - Recovery time after software reset depends on the interrupted operation.
// - Parameter read (single-line mode only): 5Ah, three address bytes, one dummy, data until deselect.
// - Dynamic protection bits are volatile and default to protected.
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH
`define FSR_CLK_MHZ 100
`define FSR_OP_GANG_LOCK 8'h7e
`define FSR_OP_GANG_UNLOCK 8'h98
`define FSR_OP_WRITE_ENABLE_CMD 8'h06
`define FSR_OP_WRITE_DISABLE_CMD 8'h04
`define FSR_OP_RESUME 8'h30
`define FSR_OP_PARAM 8'h5a
`define FSR_OP_QUAD_ON 8'h35
`define FSR_OP_QUAD_OFF 8'hf5
`define FSR_OP_RST_ARM 8'h66
`define FSR_OP_RST 8'h99
`define FSR_OP_NOP 8'h00
`define FSR_LAT_GROUP 8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'hec, 8'hed, 8'hee, 8'h0c, 8'hbc, 8'h3c, \
  `FSR_OP_PARAM, 8'h9f, 8'haf, 8'hc0, 8'hb1, 8'hc1, `FSR_OP_WRITE_ENABLE_CMD, `FSR_OP_RESUME, 8'h2d, 8'he2, 8'h16, \
  8'he0, `FSR_OP_QUAD_ON, `FSR_OP_QUAD_OFF
`define FSR_ANY_GROUP `FSR_OP_WRITE_DISABLE_CMD, 8'h05, 8'h15, 8'h2b, 8'hab, 8'h90, `FSR_OP_RST_ARM, `FSR_OP_RST, `FSR_OP_NOP
`define FSR_SEC_PSB_BIT 2
`define FSR_SEC_ESB_BIT 3
`define FSR_DPB_RESET 1'b1
`define FSR_PAGE_LSB 8
`define FSR_SECTOR_LSB 12
`define FSR_PARAM_ADDR_BITS 7'd32
`define FSR_PARAM_DATA_BITS 7'd40
`define FSR_RECOV_PROG_US 310
`define FSR_RECOV_ERASE_US 12000
`define FSR_RECOV_OTHER_US 40
`endif

// File: design/fsr_pkg.sv
// Types shared by the flash suspend, reset and protection command block
package fsr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BUSY = 3'b001,
    ST_SUSPENDING = 3'b010,
    ST_SUSPENDED = 3'b011,
    ST_RECOVER = 3'b100
  } fsr_state_t;
  typedef enum logic [1:0] {
    CL_NONE = 2'b00,
    CL_LATENCY = 2'b01,
    CL_ANYTIME = 2'b10
  } fsr_class_t;
  typedef struct packed {
    logic [7:0] op;
    logic [6:0] nbits;
  } fsr_frame_t;
  typedef struct packed {
    logic write_enable_latch;
    logic write_in_progress;
    logic program_suspended_flag;
    logic erase_suspended_flag;
  } fsr_status_t;
endpackage : fsr_pkg

// File: design/fsr_top.sv
// Command interpreter for gang protection, suspend/resume, software reset and parameter read
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_top #(
  parameter int NUM_SECTORS = 16,
  parameter logic [7:0] SUSPEND_OPCODE = 8'hb0,
  parameter int unsigned PROG_SUSPEND_CYC = 2000,
  parameter int unsigned ERASE_SUSPEND_CYC = 2000,
  parameter int unsigned PAGE_PROGRAM_CYC = 20000,
  parameter int unsigned SECTOR_ERASE_CYC = 40000,
  parameter int unsigned RECOV_PROG_CYC = `FSR_RECOV_PROG_US * `FSR_CLK_MHZ,
  parameter int unsigned RECOV_ERASE_CYC = `FSR_RECOV_ERASE_US * `FSR_CLK_MHZ,
  parameter logic [127:0] PARAM_TABLE = 128'h0f0e0d0c0b0a09080706050403020100
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic [3:0] IO_I,
  output logic [3:0] IO_O,
  output logic [3:0] IO_OE,
  input wire logic OP_START,
  input wire logic OP_ERASE,
  input wire logic [23:0] OP_ADDR,
  input wire logic WRITE_PROTECT_SELECT_DONE,
  input wire logic CONT_READ_ACTIVE,
  input wire logic [NUM_SECTORS-1:0] SOLID_PROTECT_BIT,
  input wire logic [23:0] ARRAY_READ_ADDR,
  output fsr_pkg::fsr_status_t STATUS,
  output logic [7:0] SECURITY_STATUS,
  output logic FOUR_LINE_COMMAND_MODE,
  output logic [NUM_SECTORS-1:0] DYNAMIC_PROTECT_BIT,
  output logic [NUM_SECTORS-1:0] SECTOR_PROTECTED,
  output logic ARRAY_READ_ALLOWED,
  output logic CMD_ACCEPT,
  output logic [7:0] CMD_OPCODE,
  output logic READY,
  output logic OP_ABORT
);
  import fsr_pkg::*;

  localparam int unsigned RECOV_OTHER_CYC = `FSR_RECOV_OTHER_US * `FSR_CLK_MHZ;

  // ---------------- Link side, clocked by SCLK ----------------
  logic first_q;
  logic mode_l;
  logic [6:0] cnt_q;
  logic [31:0] sh_q;
  logic [7:0] lop_q;
  logic [23:0] laddr_q;
  logic [3:0] io_o_q;
  logic [3:0] io_oe_q;
  logic [7:0] ptr_q;
  logic [2:0] bitn_q;
  logic [6:0] cnt_base;
  logic [6:0] cnt_nx;
  logic [31:0] sh_base;
  logic [31:0] sh_nx;
  logic param_go;

  // Table bit index is {byte, bit}, so the byte pointer wraps at 16 on its own

  // Marks the first edge of a frame; cnt_q, sh_q, lop_q and laddr_q keep their value after
  // deselect so the core can read the finished frame once CS_N has synchronised.
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // Line mode is taken at select time; the core only changes it between frames
  always_ff @(negedge CS_N) begin
    mode_l <= FOUR_LINE_COMMAND_MODE;
  end

  always_comb begin
    cnt_base = first_q ? 7'd0 : cnt_q;
    sh_base = first_q ? 32'h0 : sh_q;
    sh_nx = mode_l ? {sh_base[27:0], IO_I} : {sh_base[30:0], IO_I[0]};
    if (cnt_base >= 7'd120) begin
      cnt_nx = cnt_base;
    end else begin
      cnt_nx = cnt_base + (mode_l ? 7'd4 : 7'd1);
    end
  end

  // Upper lines are ignored in single-line mode, so one byte is 8 or 2 clocks
  always_ff @(posedge SCLK) begin
    cnt_q <= cnt_nx;
    sh_q <= sh_nx;
    if (cnt_nx == 7'd8) begin
      lop_q <= sh_nx[7:0];
    end
    if (cnt_nx == `FSR_PARAM_ADDR_BITS) begin
      laddr_q <= sh_nx[23:0];
    end
  end

  assign param_go = (lop_q == `FSR_OP_PARAM) && !mode_l && (cnt_q >= `FSR_PARAM_DATA_BITS);

  // Data changes on the falling edge so the host samples a settled bit
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      io_o_q <= 4'h0;
      io_oe_q <= 4'h0;
      ptr_q <= 8'h00;
      bitn_q <= 3'd0;
    end else if (param_go) begin
      io_oe_q <= 4'h2;
      if (io_oe_q == 4'h0) begin
        io_o_q <= {2'b00, PARAM_TABLE[{laddr_q[3:0], 3'd7}], 1'b0};
        ptr_q <= laddr_q[7:0];
        bitn_q <= 3'd6;
      end else begin
        io_o_q <= {2'b00, PARAM_TABLE[{ptr_q[3:0], bitn_q}], 1'b0};
        bitn_q <= bitn_q - 3'd1;
        if (bitn_q == 3'd0) begin
          ptr_q <= ptr_q + 8'h01;
        end
      end
    end
  end

  assign IO_O = io_o_q;
  assign IO_OE = io_oe_q;

  // ---------------- Core side, clocked by CLK ----------------
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  fsr_frame_t frm;
  fsr_state_t state_q;
  fsr_class_t cls;
  logic [31:0] tmr_q;
  logic [31:0] rem_q;
  logic erase_q;
  logic [23:0] op_addr_q;
  logic wel_q;
  logic wip_q;
  logic psb_q;
  logic esb_q;
  logic four_q;
  logic armed_q;
  logic [NUM_SECTORS-1:0] dpb_q;
  logic [NUM_SECTORS-1:0] prot_q;
  logic cmd_accept_q;
  logic [7:0] cmd_op_q;
  logic ready_q;
  logic abort_q;
  logic read_ok_q;
  logic fr_end;
  logic cmd_ok;
  logic aligned;
  logic allowed;
  logic accept;
  logic do_reset;
  logic susp_req;
  logic susp_enter;
  logic resume;
  logic done;
  logic in_op;
  logic addr_hit;
  logic gang_ok;

  function automatic fsr_class_t op_class(input logic [7:0] op);
    case (op)
      `FSR_LAT_GROUP: op_class = CL_LATENCY;
      `FSR_ANY_GROUP: op_class = CL_ANYTIME;
      default: op_class = CL_NONE;
    endcase
  endfunction : op_class

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else begin
      cs_s1 <= CS_N;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  // Frame words are read only after deselect is seen here, when SCLK is idle
  assign frm = '{op: lop_q, nbits: cnt_q};
  assign fr_end = cs_s2 && !cs_s3;
  assign cmd_ok = fr_end && (frm.nbits >= 7'd8);
  assign aligned = (frm.nbits[2:0] == 3'd0);
  assign cls = op_class(frm.op);
  assign in_op = (state_q == ST_BUSY) || (state_q == ST_SUSPENDING) || (state_q == ST_SUSPENDED);

  always_comb begin
    case (state_q)
      ST_IDLE: allowed = 1'b1;
      ST_BUSY: allowed = (cls == CL_ANYTIME) || (frm.op == SUSPEND_OPCODE);
      ST_SUSPENDING: allowed = (cls == CL_ANYTIME);
      ST_SUSPENDED: allowed = (cls != CL_NONE);
      default: allowed = 1'b0;
    endcase
  end

  assign accept = cmd_ok && allowed;
  assign do_reset = accept && (frm.op == `FSR_OP_RST) && armed_q;
  assign susp_req = accept && (state_q == ST_BUSY) && (frm.op == SUSPEND_OPCODE);
  assign susp_enter = (state_q == ST_SUSPENDING) && (tmr_q <= 32'd1);
  assign resume = accept && (state_q == ST_SUSPENDED) && (frm.op == `FSR_OP_RESUME) && !CONT_READ_ACTIVE;
  assign done = (state_q == ST_BUSY) && (rem_q <= 32'd1) && !susp_req;
  assign gang_ok = accept && aligned && WRITE_PROTECT_SELECT_DONE && wel_q;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      tmr_q <= 32'd0;
      rem_q <= 32'd0;
      erase_q <= 1'b0;
      op_addr_q <= 24'h0;
    end else if (do_reset) begin
      state_q <= ST_RECOVER;
      if (in_op) begin
        tmr_q <= erase_q ? RECOV_ERASE_CYC : RECOV_PROG_CYC;
      end else begin
        tmr_q <= RECOV_OTHER_CYC;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (OP_START) begin
            state_q <= ST_BUSY;
            rem_q <= OP_ERASE ? SECTOR_ERASE_CYC : PAGE_PROGRAM_CYC;
            erase_q <= OP_ERASE;
            op_addr_q <= OP_ADDR;
          end
        end
        ST_BUSY: begin
          if (susp_req) begin
            state_q <= ST_SUSPENDING;
            tmr_q <= erase_q ? ERASE_SUSPEND_CYC : PROG_SUSPEND_CYC;
          end else if (done) begin
            state_q <= ST_IDLE;
          end else begin
            rem_q <= rem_q - 32'd1;
          end
        end
        ST_SUSPENDING: begin
          if (susp_enter) begin
            state_q <= ST_SUSPENDED;
          end else begin
            tmr_q <= tmr_q - 32'd1;
          end
        end
        ST_SUSPENDED: begin
          if (resume) begin
            state_q <= ST_BUSY;
          end
        end
        ST_RECOVER: begin
          if (tmr_q <= 32'd1) begin
            state_q <= ST_IDLE;
          end else begin
            tmr_q <= tmr_q - 32'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Status bits; the suspended operation keeps its remaining time in rem_q
  always_ff @(posedge CLK) begin
    if (RESET || do_reset) begin
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      psb_q <= 1'b0;
      esb_q <= 1'b0;
    end else if (susp_enter) begin
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      psb_q <= !erase_q;
      esb_q <= erase_q;
    end else if (resume) begin
      wel_q <= 1'b1;
      wip_q <= 1'b1;
      psb_q <= 1'b0;
      esb_q <= 1'b0;
    end else if (done) begin
      wel_q <= 1'b0;
      wip_q <= 1'b0;
    end else if (state_q == ST_IDLE && OP_START) begin
      wip_q <= 1'b1;
    end else if (accept && frm.op == `FSR_OP_WRITE_ENABLE_CMD) begin
      wel_q <= 1'b1;
    end else if (accept && frm.op == `FSR_OP_WRITE_DISABLE_CMD) begin
      wel_q <= 1'b0;
    end else if (gang_ok && (frm.op == `FSR_OP_GANG_LOCK || frm.op == `FSR_OP_GANG_UNLOCK)) begin
      wel_q <= 1'b0;
    end
  end

  // Any complete command, even an ignored one, drops a pending arm
  always_ff @(posedge CLK) begin
    if (RESET) begin
      armed_q <= 1'b0;
    end else if (cmd_ok) begin
      armed_q <= accept && (frm.op == `FSR_OP_RST_ARM);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || do_reset) begin
      four_q <= 1'b0;
    end else if (accept && frm.op == `FSR_OP_QUAD_ON) begin
      four_q <= 1'b1;
    end else if (accept && frm.op == `FSR_OP_QUAD_OFF) begin
      four_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || do_reset) begin
      dpb_q <= {NUM_SECTORS{`FSR_DPB_RESET}};
    end else if (gang_ok && frm.op == `FSR_OP_GANG_LOCK) begin
      dpb_q <= {NUM_SECTORS{1'b1}};
    end else if (gang_ok && frm.op == `FSR_OP_GANG_UNLOCK) begin
      dpb_q <= {NUM_SECTORS{1'b0}};
    end
  end

  for (genvar i = 0; i < NUM_SECTORS; i++) begin : g_sector
    always_ff @(posedge CLK) begin
      if (RESET) begin
        prot_q[i] <= 1'b1;
      end else begin
        prot_q[i] <= dpb_q[i] | SOLID_PROTECT_BIT[i];
      end
    end
  end

  assign addr_hit = erase_q ? (ARRAY_READ_ADDR[23:`FSR_SECTOR_LSB] == op_addr_q[23:`FSR_SECTOR_LSB])
                            : (ARRAY_READ_ADDR[23:`FSR_PAGE_LSB] == op_addr_q[23:`FSR_PAGE_LSB]);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      read_ok_q <= 1'b0;
      cmd_accept_q <= 1'b0;
      cmd_op_q <= 8'h00;
      ready_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      read_ok_q <= (state_q == ST_IDLE) || (state_q == ST_SUSPENDED && !addr_hit);
      cmd_accept_q <= accept;
      if (accept) begin
        cmd_op_q <= frm.op;
      end
      ready_q <= (state_q != ST_RECOVER) && !do_reset;
      abort_q <= do_reset && in_op;
    end
  end

  always_comb begin
    SECURITY_STATUS = 8'h00;
    SECURITY_STATUS[`FSR_SEC_PSB_BIT] = psb_q;
    SECURITY_STATUS[`FSR_SEC_ESB_BIT] = esb_q;
  end

  assign STATUS = '{write_enable_latch: wel_q, write_in_progress: wip_q,
                    program_suspended_flag: psb_q, erase_suspended_flag: esb_q};
  assign FOUR_LINE_COMMAND_MODE = four_q;
  assign DYNAMIC_PROTECT_BIT = dpb_q;
  assign SECTOR_PROTECTED = prot_q;
  assign ARRAY_READ_ALLOWED = read_ok_q;
  assign CMD_ACCEPT = cmd_accept_q;
  assign CMD_OPCODE = cmd_op_q;
  assign READY = ready_q;
  assign OP_ABORT = abort_q;

  // ---------------- Checks ----------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  gang_write_protect_select_cmd_a:
    assert property (cmd_ok && !WRITE_PROTECT_SELECT_DONE && !do_reset |=> $stable(dpb_q))
    else $error("gang op acted without write-protect-select");
  gang_lock_a:
    assert property (gang_ok && frm.op == `FSR_OP_GANG_LOCK |=> (&dpb_q) && !wel_q)
    else $error("gang lock did not protect all sectors");
  gang_align_a:
    assert property (cmd_ok && !aligned && !do_reset |=> $stable(dpb_q))
    else $error("unaligned gang op changed protection");
  sect_state_a:
    assert property (!SECTOR_PROTECTED[0] |-> !$past(dpb_q[0]) && !$past(SOLID_PROTECT_BIT[0]))
    else $error("sector unprotected with a protect bit set");
  susp_read_a:
    assert property (state_q == ST_SUSPENDED && addr_hit ##1 addr_hit |-> !ARRAY_READ_ALLOWED)
    else $error("read allowed inside suspended region");
  susp_enter_a:
    assert property ($rose(psb_q) || $rose(esb_q) |-> $past(state_q) == ST_SUSPENDING && !wel_q)
    else $error("suspend flag set without latency");
  susp_lat_a:
    assert property (state_q == ST_SUSPENDING && cmd_ok && cls == CL_LATENCY |=> !CMD_ACCEPT)
    else $error("latency command taken too early");
  susp_any_a:
    assert property (state_q == ST_SUSPENDING && cmd_ok && cls == CL_ANYTIME |=> CMD_ACCEPT)
    else $error("any-time command refused during suspend");
  resume_a:
    assert property (resume |=> wel_q && wip_q && !psb_q && !esb_q ##1 state_q == ST_BUSY)
    else $error("resume did not restore status");
  done_a:
    assert property (done && !do_reset |=> !wel_q && !wip_q && state_q == ST_IDLE)
    else $error("completion left latch or busy set");
  resume_cont_a:
    assert property (state_q == ST_SUSPENDED && CONT_READ_ACTIVE && !do_reset |=> state_q == ST_SUSPENDED)
    else $error("resume honoured in enhancement mode");
  rst_arm_a:
    assert property (cmd_ok && frm.op == `FSR_OP_RST && !armed_q && state_q != ST_RECOVER |=> state_q != ST_RECOVER)
    else $error("reset ran without arm");
  swreset_a:
    assert property (do_reset && state_q == ST_BUSY && !erase_q |=> state_q == ST_RECOVER && (&dpb_q)
                     && !wip_q && tmr_q == RECOV_PROG_CYC)
    else $error("software reset state wrong");
  susp_ignore_a:
    assert property (state_q == ST_SUSPENDED && cmd_ok && cls == CL_NONE |=> !CMD_ACCEPT && $stable(psb_q))
    else $error("foreign command taken while suspended");

  cov_suspend_c: cover property (susp_enter ##[1:1000] resume);
  cov_reset_c: cover property (do_reset && in_op);
  cov_gang_c: cover property (gang_ok && frm.op == `FSR_OP_GANG_UNLOCK);
  cov_param_c: cover property (fr_end && frm.op == `FSR_OP_PARAM && frm.nbits > `FSR_PARAM_DATA_BITS);
endmodule : fsr_top

// File: testbench/fsr_host_model.sv
// Host-side model of the serial command bus master
`timescale 1ns/1ps
module fsr_host_model (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io = 4'h5;
  end

  // Shifts n bits MSB first from the top of data, then clocks nrd bits back on line 1
  task automatic xfer(input logic [63:0] data, input int n, input bit quad, input int nrd, output logic [15:0] rd);
    int i;
    rd = 16'h0;
    #3;
    cs_n = 1'b0;
    for (i = 0; i < n + nrd; i = i + (quad ? 4 : 1)) begin
      // Unused lines keep changing so a design that looks at them is caught
      if (i < n) io = quad ? data[63-i -: 4] : {~io[3:1], data[63-i]};
      else io = ~io;
      #15;
      sclk = 1'b1;
      if (i >= n) rd = {rd[14:0], (io_oe[1] === 1'b1) ? io_o[1] : 1'bx};
      #15;
      sclk = 1'b0;
    end
    #15;
    cs_n = 1'b1;
    io = ~io;
    // Deselect time well above the three core cycles the block needs
    #60;
  endtask : xfer
endmodule : fsr_host_model

// File: testbench/fsr_top_tb.sv
// Self-checking testbench for the suspend, reset and protection command block
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_top_tb;
  import fsr_pkg::*;
  localparam int SUSP_CYC = 100;
  localparam int RP_CYC = 50;
  localparam int RE_CYC = 80;
  localparam int RO_CYC = `FSR_RECOV_OTHER_US * `FSR_CLK_MHZ;
  localparam logic [7:0] SUSP_OP = 8'hb0;
  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] op;
    logic write_protect_select_cmd;
    logic [15:0] solid;
    logic [15:0] exp_dpb;
  } fsr_row_t;
  fsr_row_t rows [5] = '{
    '{`FSR_OP_WRITE_ENABLE_CMD, `FSR_OP_GANG_UNLOCK, 1'b0, 16'h0000, 16'hffff},
    '{`FSR_OP_WRITE_ENABLE_CMD, `FSR_OP_GANG_UNLOCK, 1'b1, 16'h00f0, 16'h0000},
    '{`FSR_OP_NOP, `FSR_OP_GANG_LOCK, 1'b1, 16'h0000, 16'h0000},
    '{`FSR_OP_WRITE_ENABLE_CMD, `FSR_OP_GANG_LOCK, 1'b1, 16'h0101, 16'hffff},
    '{`FSR_OP_WRITE_ENABLE_CMD, `FSR_OP_GANG_UNLOCK, 1'b1, 16'h8001, 16'h0000}};
  logic [23:0] bad_addr [2] = '{24'h0012ff, 24'h001fff};
  logic [23:0] good_addr [2] = '{24'h001300, 24'h002000};
  logic clk, reset, sclk, cs_n, op_start, op_erase, write_protect_select_cmd, cont_rd;
  logic quad_mode, read_ok, cmd_accept, ready, op_abort;
  logic [3:0] io_i, io_o, io_oe;
  logic [23:0] op_addr, rd_addr;
  logic [15:0] solid, dynamic_protect_bit, sect_prot, rd;
  logic [7:0] sec_status, cmd_opcode;
  fsr_status_t status;
  bit qm;
  int error_cnt, comparisons, acc_cnt, abort_cnt, low_cnt, a, l, i, k;

  fsr_host_model host (.sclk(sclk), .cs_n(cs_n), .io(io_i), .io_o(io_o), .io_oe(io_oe));
  fsr_top #(.SUSPEND_OPCODE(SUSP_OP), .PROG_SUSPEND_CYC(SUSP_CYC), .ERASE_SUSPEND_CYC(SUSP_CYC),
    .PAGE_PROGRAM_CYC(400), .SECTOR_ERASE_CYC(600), .RECOV_PROG_CYC(RP_CYC), .RECOV_ERASE_CYC(RE_CYC)) dut (
    .CLK(clk), .RESET(reset), .SCLK(sclk), .CS_N(cs_n), .IO_I(io_i), .IO_O(io_o), .IO_OE(io_oe),
    .OP_START(op_start), .OP_ERASE(op_erase), .OP_ADDR(op_addr), .WRITE_PROTECT_SELECT_DONE(write_protect_select_cmd),
    .CONT_READ_ACTIVE(cont_rd), .SOLID_PROTECT_BIT(solid), .ARRAY_READ_ADDR(rd_addr), .STATUS(status),
    .SECURITY_STATUS(sec_status), .FOUR_LINE_COMMAND_MODE(quad_mode), .DYNAMIC_PROTECT_BIT(dynamic_protect_bit),
    .SECTOR_PROTECTED(sect_prot), .ARRAY_READ_ALLOWED(read_ok), .CMD_ACCEPT(cmd_accept),
    .CMD_OPCODE(cmd_opcode), .READY(ready), .OP_ABORT(op_abort));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulses are counted here so that no check has to land on the exact cycle
  always @(posedge clk) begin
    if (cmd_accept === 1'b1) acc_cnt <= acc_cnt + 1;
    if (op_abort === 1'b1) abort_cnt <= abort_cnt + 1;
    if (ready === 1'b0 && reset === 1'b0) low_cnt <= low_cnt + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic send(input logic [7:0] op, input int n);
    host.xfer({op, 56'h0}, n, qm, 0, rd);
    // Core-side inputs then change only on the falling clock edge
    @(negedge clk);
  endtask : send

  task automatic start_op(input logic er, input logic [23:0] ad);
    @(negedge clk);
    op_erase = er;
    op_addr = ad;
    op_start = 1'b1;
    @(negedge clk);
    op_start = 1'b0;
  endtask : start_op

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    {op_start, op_erase, write_protect_select_cmd, cont_rd} = 4'h0;
    op_addr = 24'h0;
    rd_addr = 24'h0;
    solid = 16'h0;
    cyc(6);
    reset = 1'b0;
    cyc(4);
    chk(dynamic_protect_bit, 16'hffff);
    chk(status, 4'h0);
    for (i = 0; i < 5; i++) begin
      write_protect_select_cmd = rows[i].write_protect_select_cmd;
      solid = rows[i].solid;
      a = acc_cnt;
      send(rows[i].pre, 8);
      send(rows[i].op, 8);
      chk(acc_cnt, a + 2);
      chk(cmd_opcode, rows[i].op);
      chk(dynamic_protect_bit, rows[i].exp_dpb);
      chk(sect_prot, rows[i].exp_dpb | rows[i].solid);
    end
    send(`FSR_OP_WRITE_ENABLE_CMD, 8);
    send(`FSR_OP_GANG_LOCK, 12);
    chk(dynamic_protect_bit, 16'h0000);
    send(`FSR_OP_WRITE_DISABLE_CMD, 8);
    send(`FSR_OP_GANG_LOCK, 8);
    chk(dynamic_protect_bit, 16'h0000);
    send(`FSR_OP_QUAD_ON, 8);
    chk(quad_mode, 1);
    qm = 1'b1;
    a = acc_cnt;
    send(`FSR_OP_NOP, 8);
    chk(acc_cnt, a + 1);
    send(`FSR_OP_QUAD_OFF, 8);
    qm = 1'b0;
    chk(quad_mode, 0);
    host.xfer({`FSR_OP_PARAM, 24'h00000f, 8'h00, 24'h0}, 40, 1'b0, 16, rd);
    chk(rd, 16'h0f00);
    for (k = 0; k < 2; k++) begin
      start_op(k[0], 24'h001234);
      chk(status.write_in_progress, 1);
      a = acc_cnt;
      send(SUSP_OP, 8);
      chk(sec_status, 8'h00);
      send(8'h03, 8);
      send(8'h05, 8);
      chk(acc_cnt, a + 2);
      cyc(SUSP_CYC);
      chk(sec_status, k ? 8'h08 : 8'h04);
      chk(status, k ? 4'b0001 : 4'b0010);
      rd_addr = bad_addr[k];
      cyc(2);
      chk(read_ok, 0);
      rd_addr = good_addr[k];
      cyc(2);
      chk(read_ok, 1);
      a = acc_cnt;
      send(8'h02, 8);
      send(8'h03, 8);
      chk(acc_cnt, a + 1);
      cont_rd = 1'b1;
      send(`FSR_OP_RESUME, 8);
      chk(sec_status, k ? 8'h08 : 8'h04);
      cont_rd = 1'b0;
      send(`FSR_OP_RESUME, 8);
      chk(sec_status, 8'h00);
      chk(status[3:2], 2'b11);
      // Nothing else is sent until the resumed operation has run out
      for (i = 0; i < 1000 && status.write_in_progress !== 1'b0; i++) @(negedge clk);
      chk(status, 4'h0);
    end
    l = low_cnt;
    send(`FSR_OP_RST_ARM, 8);
    send(`FSR_OP_NOP, 8);
    send(`FSR_OP_RST, 8);
    cyc(10);
    chk(low_cnt, l);
    for (k = 0; k < 2; k++) begin
      start_op(k[0], 24'h000000);
      a = abort_cnt;
      l = low_cnt;
      send(`FSR_OP_RST_ARM, 8);
      send(`FSR_OP_RST, 8);
      for (i = 0; i < 300 && ready !== 1'b1; i++) @(negedge clk);
      cyc(2);
      chk(abort_cnt, a + 1);
      chk((low_cnt - l >= (k ? RE_CYC : RP_CYC) - 1) && (low_cnt - l <= (k ? RE_CYC : RP_CYC) + 3), 1);
      chk(status, 4'h0);
      chk(dynamic_protect_bit, 16'hffff);
    end
    // Reset from idle in four-line mode: fixed recovery, mode back to single-line
    send(`FSR_OP_QUAD_ON, 8);
    qm = 1'b1;
    a = abort_cnt;
    l = low_cnt;
    send(`FSR_OP_RST_ARM, 8);
    send(`FSR_OP_RST, 8);
    qm = 1'b0;
    for (i = 0; i < 4100 && ready !== 1'b1; i++) @(negedge clk);
    cyc(2);
    chk(abort_cnt, a);
    chk(quad_mode, 0);
    chk((low_cnt - l >= RO_CYC - 1) && (low_cnt - l <= RO_CYC + 3), 1);
    give_verdict();
  end
endmodule : fsr_top_tb
